// file: pkg/plc_pkg.sv
// Constants for the crossover, loopback and receive error counter control block
package plc_pkg;
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned TICK_US = 1;
  localparam int unsigned TICK_CYC = (TICK_US * CLK_MHZ < 1) ? 1 : TICK_US * CLK_MHZ;
  localparam int unsigned MDIX_SEARCH_US = 100;
  localparam int unsigned MDIX_SEARCH_TICKS = MDIX_SEARCH_US / TICK_US;
  localparam int unsigned MII_READY_MS = 2;
  localparam int unsigned MII_READY_TICKS = MII_READY_MS * 1000 / TICK_US;
  localparam int unsigned MII_READY_CYC = MII_READY_TICKS * TICK_CYC;
  localparam int unsigned TIMER_W = 16;

  localparam logic [4:0] ADDR_PHY_SPECIAL = 5'h12;
  localparam logic [4:0] ADDR_LOOPBACK = 5'h13;
  localparam logic [4:0] ADDR_RX_ERR = 5'h14;
  localparam logic [4:0] ADDR_LINK_STATUS = 5'h1A;

  localparam int unsigned LB_MII = 15;
  localparam int unsigned LB_DIGITAL = 12;
  localparam int unsigned LB_LINE_DRIVER = 10;
  localparam int unsigned LB_REMOTE = 9;
  localparam int unsigned LB_CABLE = 7;
  localparam int unsigned LB_TX_SUPPRESS = 6;
  localparam int unsigned LB_FORCE_LINK = 0;
  localparam logic [15:0] LB_WRITE_MASK = 16'h96C1;
  localparam logic [15:0] LB_RESET = 16'h1040;

  localparam int unsigned PS_COUNT_FALSE = 14;
  localparam int unsigned PS_COUNT_SYMBOL = 13;
  localparam int unsigned PS_AUTO_XOVER = 10;
  localparam int unsigned PS_MANUAL_MDIX = 9;
  localparam logic [15:0] PS_WRITE_MASK = 16'h6600;
  localparam logic [15:0] PS_RESET = 16'h0400;

  localparam int unsigned ST_LINK = 6;

  localparam logic [1:0] SPEED_1000 = 2'h2;
  localparam logic [15:0] ERR_MAX = 16'hFFFF;

  typedef enum logic [1:0] {
    PLC_SRCH_MDI = 2'b00,
    PLC_SRCH_MDIX = 2'b01,
    PLC_LOCKED = 2'b11
  } plc_xover_e;
endpackage

// file: pkg/plc_cnt_if.sv
// Carrier between the control top and the receive error counter
`timescale 1ns/100ps
interface plc_cnt_if;
  logic count_symbol;
  logic count_false;
  logic ev_symbol;
  logic ev_crc;
  logic ev_false;
  logic rd_clear;
  logic [15:0] count;
  modport ctrl (output count_symbol, count_false, ev_symbol, ev_crc, ev_false, rd_clear, input count);
  modport cnt (input count_symbol, count_false, ev_symbol, ev_crc, ev_false, rd_clear, output count);
endinterface

// file: hdl/plc_err_cnt.sv
// Receive error counter: selectable error kinds, saturating, cleared on read
`timescale 1ns/100ps
module plc_err_cnt
  import plc_pkg::*;
(
  input wire logic clock_i, // 10 MHz clock
  input wire logic resetn_i, // Async reset, active low
  plc_cnt_if.cnt bus // Events, selects, clear and count
);
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [1:0] inc;
  logic [16:0] sum;

  always_comb begin
    inc = 2'd0;
    if (bus.count_symbol ? bus.ev_symbol : bus.ev_crc) begin
      inc = inc + 2'd1;
    end
    if (bus.count_false && bus.ev_false) begin
      inc = inc + 2'd1;
    end
    // Events in the clearing cycle are kept in the fresh count
    sum = (bus.rd_clear ? 17'd0 : {1'b0, count_r}) + {15'd0, inc};
    count_nxt = sum[16] ? ERR_MAX : sum[15:0];
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_r <= 16'h0000;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign bus.count = count_r;
endmodule // plc_err_cnt

// file: hdl/plc_top.sv
// Crossover, loopback and receive error counter control of the PHY
// Operation
// - Auto crossover resolves itself, else manual bit
// - Lane roles follow MDI or MDI-X per speed
// - C/D pair swap corrected even in manual
// - Loopback bit 15 selects MII loopback, reset 0
// - Bit 12 enables all-digital loopback, reset 1
// - Bit 10 enables line-driver loopback, reset 0
// - Bit 9 remote loopback returns line data
// - Bit 7 enables external cable loopback, reset 0
// - Bit 6 suppresses transmit in digital loopback
// - MII loopback link status follows force flag
// - Other loopbacks set link when link up
// - Status word 26 bit 6 shows link
// - Data ready: MII after delay, else remote never
// - Sixteen-bit error counter clears on read
// - Control word 18 bits select counted errors
// - Symbol or CRC errors, plus false carrier
`timescale 1ns/100ps
module plc_top
  import plc_pkg::*;
#(
  parameter int unsigned MII_READY_T = plc_pkg::MII_READY_TICKS // MII data ready delay in 1 us ticks
) (
  input wire logic clock_i, // 10 MHz clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic [4:0] reg_addr_i, // Management register number
  input wire logic [15:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  output logic [15:0] reg_rdata_o, // Read data
  output logic reg_rvalid_o, // Read data valid pulse
  input wire logic link_up_i, // Line link is up
  input wire logic [1:0] speed_i, // 0 10M, 1 100M, 2 1000M
  input wire logic cd_swap_i, // C/D pair swap detected
  input wire logic ev_symbol_i, // Symbol error pulse
  input wire logic ev_crc_i, // CRC error pulse
  input wire logic ev_false_i, // False carrier pulse
  output logic mdix_o, // MDI-X active
  output logic [3:0] lane_tx_o, // 10/100: lane transmits
  output logic [7:0] lane_tx_pair_o, // 1000: tx pair per lane, 2 bits each
  output logic [7:0] lane_rx_pair_o, // 1000: rx pair per lane, 2 bits each
  output logic [4:0] loop_mode_o, // MII, digital, line driver, remote, cable
  output logic tx_suppress_o, // Line transmit suppressed
  output logic remote_return_o, // Return line rx data to partner
  output logic link_status_o, // Reported link status
  output logic data_ready_o // Ready for MAC data
);
  plc_cnt_if cbus ();

  logic [15:0] lb_r;
  logic [15:0] lb_nxt;
  logic [15:0] ps_r;
  logic [15:0] ps_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;

  always_comb begin
    lb_nxt = lb_r;
    ps_nxt = ps_r;
    if (reg_wr_i && reg_addr_i == ADDR_LOOPBACK) begin
      lb_nxt = reg_wdata_i & LB_WRITE_MASK;
    end
    if (reg_wr_i && reg_addr_i == ADDR_PHY_SPECIAL) begin
      ps_nxt = reg_wdata_i & PS_WRITE_MASK;
    end
    rvalid_nxt = reg_rd_i;
    rdata_nxt = 16'h0000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_LOOPBACK: rdata_nxt = lb_r;
        ADDR_PHY_SPECIAL: rdata_nxt = ps_r;
        ADDR_RX_ERR: rdata_nxt = cbus.count;
        ADDR_LINK_STATUS: rdata_nxt = {9'd0, link_status_o, 6'd0};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lb_r <= LB_RESET;
      ps_r <= PS_RESET;
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      lb_r <= lb_nxt;
      ps_r <= ps_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign reg_rvalid_o = rvalid_r;

  // Error counter hookup
  assign cbus.count_symbol = ps_r[PS_COUNT_SYMBOL];
  assign cbus.count_false = ps_r[PS_COUNT_FALSE];
  assign cbus.ev_symbol = ev_symbol_i;
  assign cbus.ev_crc = ev_crc_i;
  assign cbus.ev_false = ev_false_i;
  assign cbus.rd_clear = reg_rd_i && reg_addr_i == ADDR_RX_ERR;

  plc_err_cnt u_err_cnt (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .bus(cbus)
  );

  // One microsecond tick divider
  logic [3:0] div_r;
  logic [3:0] div_nxt;
  logic tick;

  always_comb begin
    tick = (div_r == 4'(TICK_CYC - 1));
    div_nxt = tick ? 4'd0 : div_r + 4'd1;
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_r <= 4'd0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // Automatic crossover search: alternate until the link comes up
  plc_xover_e xo_r;
  plc_xover_e xo_nxt;
  logic xo_mdix_r;
  logic xo_mdix_nxt;
  logic [TIMER_W-1:0] srch_r;
  logic [TIMER_W-1:0] srch_nxt;
  logic srch_done;

  always_comb begin
    xo_nxt = xo_r;
    xo_mdix_nxt = xo_mdix_r;
    srch_done = (srch_r == TIMER_W'(MDIX_SEARCH_TICKS - 1)) && tick;
    srch_nxt = srch_r;
    if (tick) begin
      srch_nxt = srch_done ? '0 : srch_r + 1'b1;
    end
    unique case (xo_r)
      PLC_SRCH_MDI: begin
        xo_mdix_nxt = 1'b0;
        if (link_up_i) begin
          xo_nxt = PLC_LOCKED;
        end else if (srch_done) begin
          xo_nxt = PLC_SRCH_MDIX;
        end
      end
      PLC_SRCH_MDIX: begin
        xo_mdix_nxt = 1'b1;
        if (link_up_i) begin
          xo_nxt = PLC_LOCKED;
        end else if (srch_done) begin
          xo_nxt = PLC_SRCH_MDI;
        end
      end
      PLC_LOCKED: begin
        srch_nxt = '0;
        if (!link_up_i) begin
          xo_nxt = PLC_SRCH_MDI;
        end
      end
      default: begin
        xo_nxt = PLC_SRCH_MDI;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      xo_r <= PLC_SRCH_MDI;
      xo_mdix_r <= 1'b0;
      srch_r <= '0;
    end else begin
      xo_r <= xo_nxt;
      xo_mdix_r <= xo_mdix_nxt;
      srch_r <= srch_nxt;
    end
  end

  // Lane mapping and loopback outputs
  logic mdix_sel;
  logic mii_lb;
  logic [4:0] modes;
  logic link_nxt;
  logic ready_nxt;
  logic [TIMER_W-1:0] mii_t_r;
  logic [TIMER_W-1:0] mii_t_nxt;
  logic mii_ok;
  logic [7:0] txp_nxt;
  logic [7:0] rxp_nxt;

  assign mdix_sel = ps_r[PS_AUTO_XOVER] ? xo_mdix_nxt : ps_r[PS_MANUAL_MDIX];

  genvar li;
  generate
    for (li = 0; li < 4; li++) begin : g_lane
      localparam logic [1:0] LANE = 2'(li);
      // Lanes 2/3 swap is fixed up whatever the crossover mode
      assign txp_nxt[2*li+:2] = LANE ^ {1'b0, mdix_sel ^ (LANE[1] & cd_swap_i)};
      assign rxp_nxt[2*li+:2] = txp_nxt[2*li+:2] ^ 2'b01;
    end
  endgenerate

  always_comb begin
    mii_lb = lb_r[LB_MII];
    modes = {lb_r[LB_MII], lb_r[LB_DIGITAL], lb_r[LB_LINE_DRIVER], lb_r[LB_REMOTE], lb_r[LB_CABLE]};
    mii_ok = (mii_t_r == TIMER_W'(MII_READY_T));
    mii_t_nxt = '0;
    if (mii_lb) begin
      mii_t_nxt = (tick && !mii_ok) ? mii_t_r + 1'b1 : mii_t_r;
    end
    link_nxt = mii_lb ? lb_r[LB_FORCE_LINK] : link_up_i;
    if (mii_lb) begin
      ready_nxt = mii_ok;
    end else if (lb_r[LB_REMOTE]) begin
      ready_nxt = 1'b0;
    end else begin
      ready_nxt = link_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mii_t_r <= '0;
      mdix_o <= 1'b0;
      lane_tx_o <= 4'h0;
      lane_tx_pair_o <= 8'h00;
      lane_rx_pair_o <= 8'h00;
      loop_mode_o <= 5'h00;
      tx_suppress_o <= 1'b0;
      remote_return_o <= 1'b0;
      link_status_o <= 1'b0;
      data_ready_o <= 1'b0;
    end else begin
      mii_t_r <= mii_t_nxt;
      mdix_o <= mdix_sel;
      lane_tx_o <= (speed_i == SPEED_1000) ? 4'hF : {2'b00, mdix_sel, !mdix_sel};
      lane_tx_pair_o <= txp_nxt;
      lane_rx_pair_o <= rxp_nxt;
      loop_mode_o <= modes;
      tx_suppress_o <= lb_r[LB_DIGITAL] & lb_r[LB_TX_SUPPRESS];
      remote_return_o <= lb_r[LB_REMOTE];
      link_status_o <= link_nxt;
      data_ready_o <= ready_nxt;
    end
  end
endmodule // plc_top

// file: tb/plc_top_monitor.sv
// Port checker for the control block, with its bind
`timescale 1ns/100ps
module plc_top_monitor
  import plc_pkg::*;
(
  input wire logic clock_i, // Clock
  input wire logic resetn_i, // Reset, active low
  input wire logic [4:0] reg_addr_i, // Register
  input wire logic reg_rd_i, // Read
  input wire logic [15:0] reg_rdata_o, // Read data
  input wire logic reg_rvalid_o, // Read valid
  input wire logic link_up_i, // Line link
  input wire logic [7:0] lane_tx_pair_o, // Tx pairs
  input wire logic [7:0] lane_rx_pair_o, // Rx pairs
  input wire logic [4:0] loop_mode_o, // Modes
  input wire logic tx_suppress_o, // Tx off
  input wire logic remote_return_o, // Remote
  input wire logic link_status_o, // Link
  input wire logic data_ready_o // Ready
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  property p_rvld; reg_rd_i |=> reg_rvalid_o; endproperty
  a_rvld: assert property (p_rvld) else $error("no read valid");
  property p_st26; reg_rd_i && reg_addr_i == ADDR_LINK_STATUS |=> reg_rdata_o[ST_LINK] == $past(link_status_o); endproperty
  a_st26: assert property (p_st26) else $error("link bit");
  property p_lnk; $past(resetn_i, 2) && !loop_mode_o[4] |-> link_status_o == $past(link_up_i); endproperty
  a_lnk: assert property (p_lnk) else $error("link follow");
  property p_sup; tx_suppress_o |-> loop_mode_o[3]; endproperty
  a_sup: assert property (p_sup) else $error("suppress");
  property p_rem; remote_return_o == loop_mode_o[1]; endproperty
  a_rem: assert property (p_rem) else $error("remote");
  property p_rdyr; loop_mode_o[1] && !loop_mode_o[4] |-> !data_ready_o; endproperty
  a_rdyr: assert property (p_rdyr) else $error("remote ready");
  property p_rdyl; $past(resetn_i, 2) && loop_mode_o[4:1] == 4'h0 |-> data_ready_o == link_status_o; endproperty
  a_rdyl: assert property (p_rdyl) else $error("ready");
  property p_pair; $past(resetn_i, 2) |-> lane_rx_pair_o == (lane_tx_pair_o ^ 8'h55); endproperty
  a_pair: assert property (p_pair) else $error("pairs");
endmodule // plc_top_monitor
bind plc_top plc_top_monitor plc_top_monitor_i (
  .clock_i(clock_i),
  .resetn_i(resetn_i),
  .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o),
  .link_up_i(link_up_i),
  .lane_tx_pair_o(lane_tx_pair_o),
  .lane_rx_pair_o(lane_rx_pair_o),
  .loop_mode_o(loop_mode_o),
  .tx_suppress_o(tx_suppress_o),
  .remote_return_o(remote_return_o),
  .link_status_o(link_status_o),
  .data_ready_o(data_ready_o)
);

// file: tb/plc_line_model.sv
// Line side partner: link, speed, pair swap and error events
`timescale 1ns/100ps
module plc_line_model (
  input wire logic clock_i, // Clock
  input wire logic up_i, // Bring link up
  input wire logic [1:0] spd_i, // Speed
  input wire logic swap_i, // C/D swapped
  input wire logic [2:0] err_i, // Symbol, CRC, false carrier
  output logic link_o, // Link, two cycles late
  output logic [1:0] spd_o, // Speed seen
  output logic swap_o, // Swap seen
  output logic [2:0] ev_o // Event pulses
);
  logic [7:0] q_r = 8'h00;
  always @(posedge clock_i) begin
    q_r <= {q_r[6], up_i, spd_i, swap_i, err_i};
  end
  assign {link_o, spd_o, swap_o, ev_o} = {q_r[7], q_r[5:0]};
endmodule // plc_line_model

// file: tb/tb_top.sv
// Testbench for the crossover, loopback and error counter block
`timescale 1ns/100ps
module tb_top;
  import plc_pkg::*;
  localparam int unsigned POS [5] = '{LB_MII, LB_DIGITAL, LB_LINE_DRIVER, LB_REMOTE, LB_CABLE};
  logic clock_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, up = 1'b0, swp = 1'b0, el;
  logic [4:0] reg_addr_i = 5'h00;
  logic [15:0] reg_wdata_i = 16'h0000, exp_c = 16'h0000, d, v, snap;
  logic [1:0] spd = 2'h0, sel = 2'h0;
  logic [2:0] err = 3'h0;
  wire reg_rvalid_o, link_up_i, cd_swap_i, ev_symbol_i, ev_crc_i, ev_false_i, mdix_o, tx_suppress_o;
  wire remote_return_o, link_status_o, data_ready_o;
  wire [1:0] speed_i;
  wire [3:0] lane_tx_o;
  wire [4:0] loop_mode_o;
  wire [7:0] lane_tx_pair_o, lane_rx_pair_o;
  wire [15:0] reg_rdata_o;
  int bad_count = 0, comparisons = 0, i;
  plc_line_model plc_line_model_i (.clock_i(clock_i), .up_i(up), .spd_i(spd), .swap_i(swp), .err_i(err),
    .link_o(link_up_i), .spd_o(speed_i), .swap_o(cd_swap_i), .ev_o({ev_symbol_i, ev_crc_i, ev_false_i}));
  plc_top #(.MII_READY_T(3)) plc_top_i (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .link_up_i(link_up_i),
    .speed_i(speed_i),
    .cd_swap_i(cd_swap_i),
    .ev_symbol_i(ev_symbol_i),
    .ev_crc_i(ev_crc_i),
    .ev_false_i(ev_false_i),
    .mdix_o(mdix_o),
    .lane_tx_o(lane_tx_o),
    .lane_tx_pair_o(lane_tx_pair_o),
    .lane_rx_pair_o(lane_rx_pair_o),
    .loop_mode_o(loop_mode_o),
    .tx_suppress_o(tx_suppress_o),
    .remote_return_o(remote_return_o),
    .link_status_o(link_status_o),
    .data_ready_o(data_ready_o)
  );
  initial begin
    forever #50 clock_i = ~clock_i;
  end
  function automatic logic [7:0] pairs(input logic m, input logic s);
    // Pair per lane, lane 0 lowest: MDI A B C D, MDI-X B A D C; a C/D swap trades lanes 2 and 3
    pairs = m ? 8'hB1 : 8'hE4;
    if (s) pairs = {pairs[5:4], pairs[7:6], pairs[3:0]};
  endfunction
  always @(posedge clock_i) begin
    logic [16:0] s;
    if (reg_rd_i && reg_addr_i == ADDR_RX_ERR) begin
      snap = exp_c;
      exp_c = 16'h0000;
    end
    s = 17'(exp_c) + 17'(sel[0] ? ev_symbol_i : ev_crc_i) + 17'(sel[1] & ev_false_i);
    exp_c = (s > 17'(ERR_MAX)) ? ERR_MAX : s[15:0];
  end
  task automatic chk(input logic [15:0] g, e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] w);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= w;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hd26d));
    repeat (12) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd(ADDR_LOOPBACK);
    chk(d, LB_RESET);
    rd(ADDR_RX_ERR);
    chk(d, 16'h0000);
    for (i = 0; i < 14; i++) begin
      @(posedge clock_i);
      up <= 1'($urandom());
      v = 16'($urandom());
      if (i < 5) v = (v & 16'h0041) | (16'h0001 << POS[i]);
      wr(ADDR_LOOPBACK, v);
      repeat (50) @(posedge clock_i);
      #1;
      el = v[15] ? v[0] : up;
      chk(16'(loop_mode_o), 16'({v[15], v[12], v[10], v[9], v[7]}));
      chk(16'(tx_suppress_o), 16'(v[12] & v[6]));
      chk(16'(link_status_o), 16'(el));
      chk(16'(data_ready_o), 16'(v[15] | (!v[9] & el)));
      rd(ADDR_LINK_STATUS);
      chk(16'(d[ST_LINK]), 16'(el));
      rd(ADDR_LOOPBACK);
      chk(d, v & LB_WRITE_MASK);
    end
    for (i = 0; i < 8; i++) begin
      @(posedge clock_i);
      spd <= i[2] ? SPEED_1000 : 2'(i[1]);
      swp <= i[1];
      wr(ADDR_PHY_SPECIAL, 16'(i[0]) << PS_MANUAL_MDIX);
      chk(16'(mdix_o), 16'(i[0]));
      chk(16'(lane_tx_o), i[2] ? 16'h000f : 16'({i[0], !i[0]}));
      chk(16'(lane_tx_pair_o), 16'(pairs(i[0], i[1])));
      chk(16'(lane_rx_pair_o), 16'(pairs(!i[0], i[1])));
    end
    // Automatic crossover with the link down must try both MDI and MDI-X
    @(posedge clock_i);
    up <= 1'b0;
    wr(ADDR_PHY_SPECIAL, 16'h0001 << PS_AUTO_XOVER);
    v = 16'h0000;
    repeat (2200) begin
      @(posedge clock_i);
      #1;
      v = v | (16'h0001 << mdix_o);
    end
    chk(v, 16'h0003);
    for (i = 0; i < 4; i++) begin
      @(posedge clock_i);
      err <= 3'h0;
      wr(ADDR_PHY_SPECIAL, 16'(i) << PS_COUNT_SYMBOL);
      sel = 2'(i);
      rd(ADDR_RX_ERR);
      repeat (60) begin
        @(posedge clock_i);
        err <= 3'($urandom());
      end
      @(posedge clock_i);
      err <= 3'h0;
      repeat (2) @(posedge clock_i);
      rd(ADDR_RX_ERR);
      chk(d, snap);
      rd(ADDR_RX_ERR);
      chk(d, 16'h0000);
    end
    @(posedge clock_i);
    err <= 3'h7;
    repeat (33000) @(posedge clock_i);
    err <= 3'h0;
    repeat (2) @(posedge clock_i);
    rd(ADDR_RX_ERR);
    chk(d, ERR_MAX);
    report_and_stop();
  end
  initial begin
    #6000000;
    bad_count++;
    report_and_stop();
  end
endmodule // tb_top
